// File: atc_timer_pkg.sv
// Purpose: constants, field layouts and carrier types of the two-channel async timer.
// Assumes: byte-wide register port; one system clock at 50 MHz.
// Notes:   register offsets other than the general control word are local choices.
package atc_timer_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_GENERAL_CTRL = 8'h23;
    localparam logic [7:0] OFS_CTRL_A       = 8'h30;
    localparam logic [7:0] OFS_CTRL_B       = 8'h31;
    localparam logic [7:0] OFS_COUNT        = 8'h32;
    localparam logic [7:0] OFS_CMP_A        = 8'h33;
    localparam logic [7:0] OFS_CMP_B        = 8'h34;
    localparam logic [7:0] OFS_IRQ_MASK     = 8'h35;
    localparam logic [7:0] OFS_IRQ_FLAGS    = 8'h36;
    localparam logic [7:0] OFS_ASYNC_STATUS = 8'h37;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_FORCE_A    = 7;
    localparam int BIT_FORCE_B    = 6;
    localparam int BIT_WGM_HIGH   = 3;
    localparam int BIT_IRQ_CMP_B  = 2;
    localparam int BIT_IRQ_CMP_A  = 1;
    localparam int BIT_IRQ_OVF    = 0;
    localparam int BIT_EXT_CLK    = 6;
    localparam int BIT_ASYNC_SEL  = 5;
    localparam int BIT_BUSY_COUNT = 4;
    localparam int BIT_BUSY_CMP_A = 3;
    localparam int BIT_BUSY_CMP_B = 2;
    localparam int BIT_BUSY_CTL_A = 1;
    localparam int BIT_BUSY_CTL_B = 0;
    localparam int BIT_SYNC_MODE  = 7;
    localparam int BIT_PSR_ASYNC  = 1;
    localparam int BIT_PSR_SYNC   = 0;

    // control A: compare modes A [7:6], B [5:4], low mode bits [1:0]
    localparam logic [7:0] CTRL_A_MASK = 8'hf3;

    // ------------------------------------------------------------------
    // values after reset and encodings
    // ------------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE  = 8'h00;
    localparam logic [7:0] COUNT_MAX   = 8'hff;
    localparam logic [7:0] COUNT_BOT   = 8'h00;
    localparam logic [2:0] WGM_CTC     = 3'h2;
    localparam logic [1:0] COM_TOGGLE  = 2'h1;
    localparam logic [1:0] COM_CLEAR   = 2'h2;
    localparam logic [1:0] COM_SET     = 2'h3;
    localparam int         PRESC_WIDTH = 10;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } atc_bus_req_s;

    typedef struct packed {
        logic [7:0]             ctrl_a_tmp;
        logic [7:0]             ctrl_a;
        logic [3:0]             ctrl_b_tmp;
        logic [3:0]             ctrl_b;
        logic [7:0]             count;
        logic [7:0]             count_tmp;
        logic [7:0]             cmp_a_tmp;
        logic [7:0]             cmp_a;
        logic [7:0]             cmp_b_tmp;
        logic [7:0]             cmp_b;
        logic [2:0]             irq_mask;
        logic [2:0]             irq_flags;
        logic                   ext_clk;
        logic                   async_sel;
        logic [4:0]             busy;
        logic                   sync_mode;
        logic                   psr_async;
        logic                   psr_sync;
        logic [PRESC_WIDTH-1:0] presc;
        logic                   count_down;
        logic                   match_block;
        logic                   osc_s1;
        logic                   osc_s2;
        logic                   osc_prev;
        logic                   wave_a;
        logic                   wave_b;
        logic [7:0]             rdata;
    } atc_state_s;

endpackage

// File: atc_timer.sv
// Purpose: 8-bit timer/counter with two compare channels and async clocking.
// Assumes: oscillator pin is asynchronous to clk and much slower than it.
// Notes:   one packed state word; one combinational next-state, one register stage.
//
// Function
// RQ1: force bit applies compare output action immediately
// RQ2: forced compare raises no flag, no clear
// RQ3: force bits read zero, ignored in PWM
// RQ4: software keeps force bits zero in PWM
// RQ5: clock select: stop, direct, prescaler taps
// RQ6: counter read/write; write blocks next match
// RQ7: both compare registers checked each timer tick
// RQ8: interrupt needs enable, global bit and flag
// RQ9: compare flags set on match, cleared
// RQ10: overflow flag set on overflow or bottom
// RQ11: external clock accepted, crystal off when enabled
// RQ12: software sets external clock before async
// RQ13: async select picks clk or oscillator pin
// RQ14: software rewrites registers after async change
// RQ15: async writes set busy until transferred
// RQ16: software avoids writing while busy
// RQ17: counter reads live; others read temporary copy
// RQ18: prescaler reset bit self-clears unless sync mode
// RQ19: reserved bits read zero
// RQ20: control B bit 3 is top mode bit
//
// Implementation choice: the strobed register port.
module atc_timer (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire atc_timer_pkg::atc_bus_req_s bus_req,
    output logic [7:0]                     bus_rdata,
    input  wire logic                      timer_oscillator_in,
    input  wire logic                      global_irq_enable,
    input  wire logic [2:0]                irq_vector_ack,
    output logic [2:0]                     irq_request,
    output logic                           waveform_out_a,
    output logic                           waveform_out_a_en,
    output logic                           waveform_out_b,
    output logic                           waveform_out_b_en,
    output logic                           crystal_osc_enable,
    output logic                           ext_clock_buffer_enable
);

    atc_timer_pkg::atc_state_s s_r;
    atc_timer_pkg::atc_state_s s_nxt;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic com_action(input logic [1:0] com, input logic cur);
        logic res;
        res = cur;
        if (com == atc_timer_pkg::COM_TOGGLE) begin
            res = ~cur;
        end else if (com == atc_timer_pkg::COM_CLEAR) begin
            res = 1'b0;
        end else if (com == atc_timer_pkg::COM_SET) begin
            res = 1'b1;
        end
        return res;
    endfunction

    // mask of prescaler bits that must all be one for a tap to fire
    function automatic logic [9:0] tap_mask(input logic [2:0] sel);
        logic [9:0] m;
        m = 10'h000;
        case (sel)
            3'h2: m = 10'h007;
            3'h3: m = 10'h01f;
            3'h4: m = 10'h03f;
            3'h5: m = 10'h07f;
            3'h6: m = 10'h0ff;
            3'h7: m = 10'h3ff;
            default: m = 10'h000;
        endcase
        return m;
    endfunction

    // ------------------------------------------------------------------
    // derived decode of the working registers
    // ------------------------------------------------------------------
    logic [2:0] wgm;
    logic       pwm_mode;
    logic       phase_mode;
    logic       fast_mode;
    logic [7:0] top_value;
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [2:0] clk_sel;
    logic       src_tick;
    logic       timer_tick;
    logic       wr_en;

    always_comb begin
        wgm        = {s_r.ctrl_b[atc_timer_pkg::BIT_WGM_HIGH], s_r.ctrl_a[1:0]}; // RQ20
        pwm_mode   = wgm[0];
        phase_mode = (wgm[1:0] == 2'h1);
        fast_mode  = (wgm[1:0] == 2'h3);
        if (wgm[2] || (wgm == atc_timer_pkg::WGM_CTC)) begin
            top_value = s_r.cmp_a;
        end else begin
            top_value = atc_timer_pkg::COUNT_MAX;
        end
        com_a   = s_r.ctrl_a[7:6];
        com_b   = s_r.ctrl_a[5:4];
        clk_sel = s_r.ctrl_b[2:0];
        // RQ13: the oscillator edge is taken from the second sync stage only
        if (s_r.async_sel) begin
            src_tick = s_r.osc_s2 & ~s_r.osc_prev; // RQ13
        end else begin
            src_tick = 1'b1;
        end
        // RQ5
        if (clk_sel == 3'h0) begin
            timer_tick = 1'b0;
        end else if (clk_sel == 3'h1) begin
            timer_tick = src_tick;
        end else begin
            timer_tick = src_tick && !s_r.psr_async
                && ((s_r.presc & tap_mask(clk_sel)) == tap_mask(clk_sel));
        end
        wr_en = bus_req.wr;
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    logic       match_a;
    logic       match_b;
    logic       ovf;
    logic       at_bottom;
    logic [2:0] set_flags;
    logic [2:0] clr_flags;

    always_comb begin
        s_nxt     = s_r;
        match_a   = 1'b0;
        match_b   = 1'b0;
        ovf       = 1'b0;
        at_bottom = 1'b0;
        clr_flags = 3'h0;

        // two-flop synchroniser, then an edge register read from stage two
        s_nxt.osc_s1   = timer_oscillator_in;
        s_nxt.osc_s2   = s_r.osc_s1;
        s_nxt.osc_prev = s_r.osc_s2;

        // prescaler: held at zero while its reset bit stands
        if (s_r.psr_async) begin
            s_nxt.presc = '0; // RQ18
        end else if (src_tick && clk_sel != 3'h0) begin
            s_nxt.presc = s_r.presc + 10'h001;
        end
        // outside sync mode, stays set in async mode until a source edge has cleared the prescaler
        if (s_r.psr_async && !s_r.sync_mode && (!s_r.async_sel || src_tick)) begin
            s_nxt.psr_async = 1'b0; // RQ18
        end
        if (s_r.psr_sync && !s_r.sync_mode) begin
            s_nxt.psr_sync = 1'b0;
        end

        // counting and compare on each timer tick
        if (timer_tick) begin
            s_nxt.match_block = 1'b0;
            match_a = (s_r.count == s_r.cmp_a) && !s_r.match_block; // RQ7 RQ6
            match_b = (s_r.count == s_r.cmp_b) && !s_r.match_block; // RQ7 RQ6
            if (phase_mode) begin
                if (!s_r.count_down) begin
                    if (s_r.count == top_value) begin
                        s_nxt.count      = s_r.count - 8'h01;
                        s_nxt.count_down = 1'b1;
                    end else begin
                        s_nxt.count = s_r.count + 8'h01;
                    end
                end else if (s_r.count == atc_timer_pkg::COUNT_BOT) begin
                    s_nxt.count      = s_r.count + 8'h01;
                    s_nxt.count_down = 1'b0;
                    ovf              = 1'b1; // RQ10
                end else begin
                    s_nxt.count = s_r.count - 8'h01;
                end
            end else if (s_r.count == top_value) begin
                s_nxt.count = atc_timer_pkg::COUNT_BOT;
                at_bottom   = 1'b1;
                ovf         = fast_mode || (s_r.count == atc_timer_pkg::COUNT_MAX); // RQ10
            end else begin
                s_nxt.count = s_r.count + 8'h01;
                ovf         = (s_r.count == atc_timer_pkg::COUNT_MAX); // RQ10
            end
        end

        // waveform outputs
        if (!pwm_mode) begin
            if (match_a) begin
                s_nxt.wave_a = com_action(com_a, s_r.wave_a); // RQ7
            end
            if (match_b) begin
                s_nxt.wave_b = com_action(com_b, s_r.wave_b); // RQ7
            end
        end else if (fast_mode) begin
            if (match_a) begin
                s_nxt.wave_a = com_action(com_a, s_r.wave_a);
            end else if (at_bottom && com_a[1]) begin
                s_nxt.wave_a = ~com_a[0];
            end
            if (match_b && com_b[1]) begin
                s_nxt.wave_b = com_b[0];
            end else if (at_bottom && com_b[1]) begin
                s_nxt.wave_b = ~com_b[0];
            end
        end else begin
            if (match_a && com_a[1]) begin
                s_nxt.wave_a = com_a[0] ^ s_r.count_down;
            end else if (match_a && com_a == atc_timer_pkg::COM_TOGGLE && wgm[2]) begin
                s_nxt.wave_a = ~s_r.wave_a;
            end
            if (match_b && com_b[1]) begin
                s_nxt.wave_b = com_b[0] ^ s_r.count_down;
            end
        end

        // async mode: temporary copies move over on the next source edge
        if (s_r.async_sel && src_tick) begin
            if (s_r.busy[atc_timer_pkg::BIT_BUSY_COUNT]) begin
                s_nxt.count       = s_r.count_tmp; // RQ15
                s_nxt.match_block = 1'b1; // RQ6
            end
            if (s_r.busy[atc_timer_pkg::BIT_BUSY_CMP_A]) begin
                s_nxt.cmp_a = s_r.cmp_a_tmp;
            end
            if (s_r.busy[atc_timer_pkg::BIT_BUSY_CMP_B]) begin
                s_nxt.cmp_b = s_r.cmp_b_tmp;
            end
            if (s_r.busy[atc_timer_pkg::BIT_BUSY_CTL_A]) begin
                s_nxt.ctrl_a = s_r.ctrl_a_tmp;
            end
            if (s_r.busy[atc_timer_pkg::BIT_BUSY_CTL_B]) begin
                s_nxt.ctrl_b = s_r.ctrl_b_tmp;
            end
            s_nxt.busy = 5'h00; // RQ15
        end
        if (!s_r.async_sel) begin
            s_nxt.busy = 5'h00;
        end

        // register writes
        if (wr_en) begin
            if (bus_req.addr == atc_timer_pkg::OFS_GENERAL_CTRL) begin
                s_nxt.sync_mode = bus_req.wdata[atc_timer_pkg::BIT_SYNC_MODE];
                if (bus_req.wdata[atc_timer_pkg::BIT_PSR_ASYNC]) begin
                    s_nxt.psr_async = 1'b1; // RQ18
                end
                if (bus_req.wdata[atc_timer_pkg::BIT_PSR_SYNC]) begin
                    s_nxt.psr_sync = 1'b1;
                end
            end else if (bus_req.addr == atc_timer_pkg::OFS_CTRL_A) begin
                s_nxt.ctrl_a_tmp = bus_req.wdata & atc_timer_pkg::CTRL_A_MASK;
                if (s_r.async_sel) begin
                    s_nxt.busy[atc_timer_pkg::BIT_BUSY_CTL_A] = 1'b1; // RQ15
                end else begin
                    s_nxt.ctrl_a = bus_req.wdata & atc_timer_pkg::CTRL_A_MASK;
                end
            end else if (bus_req.addr == atc_timer_pkg::OFS_CTRL_B) begin
                s_nxt.ctrl_b_tmp = bus_req.wdata[3:0];
                if (s_r.async_sel) begin
                    s_nxt.busy[atc_timer_pkg::BIT_BUSY_CTL_B] = 1'b1; // RQ15
                end else begin
                    s_nxt.ctrl_b = bus_req.wdata[3:0];
                end
                // forced compare: output only, no flag and no counter clear
                if (!pwm_mode) begin
                    if (bus_req.wdata[atc_timer_pkg::BIT_FORCE_A]) begin
                        s_nxt.wave_a = com_action(com_a, s_r.wave_a); // RQ1 RQ2 RQ3
                    end
                    if (bus_req.wdata[atc_timer_pkg::BIT_FORCE_B]) begin
                        s_nxt.wave_b = com_action(com_b, s_r.wave_b); // RQ1 RQ2 RQ3
                    end
                end
            end else if (bus_req.addr == atc_timer_pkg::OFS_COUNT) begin
                s_nxt.count_tmp = bus_req.wdata;
                if (s_r.async_sel) begin
                    s_nxt.busy[atc_timer_pkg::BIT_BUSY_COUNT] = 1'b1; // RQ15
                end else begin
                    s_nxt.count       = bus_req.wdata; // RQ6
                    s_nxt.match_block = 1'b1; // RQ6
                end
            end else if (bus_req.addr == atc_timer_pkg::OFS_CMP_A) begin
                s_nxt.cmp_a_tmp = bus_req.wdata;
                if (s_r.async_sel) begin
                    s_nxt.busy[atc_timer_pkg::BIT_BUSY_CMP_A] = 1'b1; // RQ15
                end else begin
                    s_nxt.cmp_a = bus_req.wdata;
                end
            end else if (bus_req.addr == atc_timer_pkg::OFS_CMP_B) begin
                s_nxt.cmp_b_tmp = bus_req.wdata;
                if (s_r.async_sel) begin
                    s_nxt.busy[atc_timer_pkg::BIT_BUSY_CMP_B] = 1'b1; // RQ15
                end else begin
                    s_nxt.cmp_b = bus_req.wdata;
                end
            end else if (bus_req.addr == atc_timer_pkg::OFS_IRQ_MASK) begin
                s_nxt.irq_mask = bus_req.wdata[2:0]; // RQ8
            end else if (bus_req.addr == atc_timer_pkg::OFS_IRQ_FLAGS) begin
                clr_flags = bus_req.wdata[2:0]; // RQ9 RQ10
            end else if (bus_req.addr == atc_timer_pkg::OFS_ASYNC_STATUS) begin
                s_nxt.ext_clk   = bus_req.wdata[atc_timer_pkg::BIT_EXT_CLK]; // RQ11
                s_nxt.async_sel = bus_req.wdata[atc_timer_pkg::BIT_ASYNC_SEL]; // RQ13
            end
        end

        // flags: a hardware set in the same cycle beats any clear
        set_flags = {match_b, match_a, ovf}; // RQ9 RQ10 RQ2
        s_nxt.irq_flags = (s_r.irq_flags & ~(clr_flags | irq_vector_ack)) | set_flags; // RQ9

        // read data, one cycle after the strobe
        s_nxt.rdata = 8'h00;
        if (bus_req.rd) begin
            if (bus_req.addr == atc_timer_pkg::OFS_GENERAL_CTRL) begin
                s_nxt.rdata = {s_r.sync_mode, 5'h00, s_r.psr_async, s_r.psr_sync};
            end else if (bus_req.addr == atc_timer_pkg::OFS_CTRL_A) begin
                s_nxt.rdata = s_r.ctrl_a_tmp; // RQ17
            end else if (bus_req.addr == atc_timer_pkg::OFS_CTRL_B) begin
                s_nxt.rdata = {4'h0, s_r.ctrl_b_tmp}; // RQ3 RQ17 RQ19
            end else if (bus_req.addr == atc_timer_pkg::OFS_COUNT) begin
                s_nxt.rdata = s_r.count; // RQ17
            end else if (bus_req.addr == atc_timer_pkg::OFS_CMP_A) begin
                s_nxt.rdata = s_r.cmp_a_tmp; // RQ17
            end else if (bus_req.addr == atc_timer_pkg::OFS_CMP_B) begin
                s_nxt.rdata = s_r.cmp_b_tmp; // RQ17
            end else if (bus_req.addr == atc_timer_pkg::OFS_IRQ_MASK) begin
                s_nxt.rdata = {5'h00, s_r.irq_mask};
            end else if (bus_req.addr == atc_timer_pkg::OFS_IRQ_FLAGS) begin
                s_nxt.rdata = {5'h00, s_r.irq_flags};
            end else if (bus_req.addr == atc_timer_pkg::OFS_ASYNC_STATUS) begin
                s_nxt.rdata = {1'b0, s_r.ext_clk, s_r.async_sel, s_r.busy}; // RQ19
            end
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    always_comb begin
        bus_rdata          = s_r.rdata;
        irq_request        = s_r.irq_flags & s_r.irq_mask & {3{global_irq_enable}}; // RQ8
        waveform_out_a     = s_r.wave_a;
        waveform_out_b     = s_r.wave_b;
        waveform_out_a_en  = (com_a != 2'h0);
        waveform_out_b_en  = (com_b != 2'h0);
        crystal_osc_enable = ~s_r.ext_clk; // RQ11
        ext_clock_buffer_enable = s_r.ext_clk & s_r.async_sel; // RQ11
    end

endmodule

// File: atc_timer_props.sv
// Purpose: port-level checks of the two-channel async timer
// Assumes: one clock, synchronous active-high reset
// Notes:   sees only top-level ports, so internal state is judged by its effects
module atc_timer_props (
    input wire logic                        clk,
    input wire logic                        rst,
    input wire atc_timer_pkg::atc_bus_req_s bus_req,
    input wire logic [7:0]                  bus_rdata,
    input wire logic [2:0]                  irq_request,
    input wire logic                        global_irq_enable,
    input wire logic                        waveform_out_a,
    input wire logic                        crystal_osc_enable,
    input wire logic                        ext_clock_buffer_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ----
    // assertions
    // ----
    property p_irq_gate; irq_request != 3'h0 |-> global_irq_enable; endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without global bit");
    property p_rd_idle; !bus_req.rd |=> bus_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_unmapped; bus_req.rd && bus_req.addr == 8'h00 |=> bus_rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_status_res;
        bus_req.rd && bus_req.addr == atc_timer_pkg::OFS_ASYNC_STATUS |=> !bus_rdata[7];
    endproperty
    a_status_res: assert property (p_status_res) else $error("status bit 7 set");
    property p_ctlb_res;
        bus_req.rd && bus_req.addr == atc_timer_pkg::OFS_CTRL_B |=> bus_rdata[7:4] == 4'h0;
    endproperty
    a_ctlb_res: assert property (p_ctlb_res) else $error("control b upper bits set");
    property p_cmp_back;
        bus_req.wr && bus_req.addr == atc_timer_pkg::OFS_CMP_B ##2
        bus_req.rd && bus_req.addr == atc_timer_pkg::OFS_CMP_B |=> bus_rdata == $past(bus_req.wdata, 3);
    endproperty
    a_cmp_back: assert property (p_cmp_back) else $error("compare b readback wrong");
    property p_xtal; ext_clock_buffer_enable |-> !crystal_osc_enable; endproperty
    a_xtal: assert property (p_xtal) else $error("crystal runs with external clock");
    property p_xbuf_cause;
        $changed(ext_clock_buffer_enable)
        |-> $past(bus_req.wr && bus_req.addr == atc_timer_pkg::OFS_ASYNC_STATUS);
    endproperty
    a_xbuf_cause: assert property (p_xbuf_cause) else $error("clock buffer moved alone");
    c_irq: cover property (irq_request == 3'h7);
    c_wave: cover property ($rose(waveform_out_a));
    c_xbuf: cover property (ext_clock_buffer_enable);
endmodule

bind atc_timer atc_timer_props u_props (
    .clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .irq_request(irq_request), .global_irq_enable(global_irq_enable),
    .waveform_out_a(waveform_out_a), .crystal_osc_enable(crystal_osc_enable),
    .ext_clock_buffer_enable(ext_clock_buffer_enable)
);

// File: atc_osc_model.sv
// Purpose: external clock source on the timer oscillator pin
// Assumes: far slower than the system clock
// Notes:   idles low while disabled so no stray edge reaches the synchronizer
module atc_osc_model #(
    parameter int HALF_NS = 160
) (
    input  wire logic en,
    output logic      osc
);
    timeunit 1ns;
    timeprecision 1ps;
    initial osc = 1'b0;
    always begin
        #(HALF_NS);
        osc = en ? ~osc : 1'b0;
    end
endmodule

// File: tb.sv
// Purpose: self-checking bench of the two-channel async timer
// Assumes: 50 MHz clock, reset held for 3 cycles
// Notes:   reads queue their expected range; a monitor checks each answer
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed { logic [7:0] lo; logic [7:0] hi; } atc_note_s;
    logic                        clk = 1'b0;
    logic                        rst = 1'b1;
    atc_timer_pkg::atc_bus_req_s req = '0;
    logic [7:0]                  rdata;
    logic                        osc, wa, wa_en, wb, wb_en, xtal, xbuf;
    logic                        osc_en = 1'b0;
    logic                        gie = 1'b0;
    logic                        rd_d = 1'b0;
    logic [2:0]                  ack = 3'h0;
    logic [2:0]                  irq;
    logic [31:0]                 seed = 32'h48;
    logic [7:0]                  regs[10] = '{8'h23, 8'h30, 8'h31, 8'h32, 8'h33,
                                              8'h34, 8'h35, 8'h36, 8'h37, 8'h00};
    int                          divs[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    atc_note_s                   notes[$];
    int                          fails = 0;
    int                          samples_checked = 0;

    always #10 clk = ~clk;

    atc_timer DUT (
        .clk(clk), .rst(rst), .bus_req(req), .bus_rdata(rdata),
        .timer_oscillator_in(osc), .global_irq_enable(gie), .irq_vector_ack(ack),
        .irq_request(irq), .waveform_out_a(wa), .waveform_out_a_en(wa_en),
        .waveform_out_b(wb), .waveform_out_b_en(wb_en), .crystal_osc_enable(xtal),
        .ext_clock_buffer_enable(xbuf)
    );
    atc_osc_model u_osc (.en(osc_en), .osc(osc));

    // ----
    // helpers
    // ----
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        notes.push_back('{lo, hi});
        @(posedge clk);
        req.rd <= 1'b0;
    endtask
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        rd(a, e, e);
    endtask
    task automatic close_out;
        if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        atc_note_s n;
        rd_d <= req.rd;
        if (rd_d) begin
            n = notes.pop_front();
            check(rdata, ((n.lo <= rdata && rdata <= n.hi) === 1'b1) ? rdata : n.lo);
        end
    end

    // ----
    // scenarios
    // ----
    initial begin
        logic [7:0] va;
        logic [7:0] vb;
        tick(3);
        rst <= 1'b0;
        foreach (regs[i]) rdx(regs[i], 8'h00);
        #1 check({7'h0, xtal}, 8'h01);
        seed = xorshift(seed);
        va = seed[7:0];
        vb = seed[15:8];
        wr(8'h33, va);
        wr(8'h34, vb);
        rdx(8'h34, vb);
        rdx(8'h33, va);
        wr(8'h32, 8'hf0);
        wr(8'h31, 8'h01);
        tick(300);
        wr(8'h31, 8'h00);
        rdx(8'h36, 8'h07);
        wr(8'h35, 8'h07);
        gie <= 1'b1;
        tick(2);
        #1 check({5'h0, irq}, 8'h07);
        @(posedge clk) gie <= 1'b0;
        tick(2);
        #1 check({5'h0, irq}, 8'h00);
        @(posedge clk) ack <= 3'h1;
        tick(1);
        ack <= 3'h0;
        rdx(8'h36, 8'h06);
        wr(8'h36, 8'h06);
        rdx(8'h36, 8'h00);
        for (int i = 2; i < 8; i++) begin
            wr(8'h32, 8'h00);
            wr(8'h31, 8'(i));
            tick(4 * divs[i]);
            wr(8'h31, 8'h00);
            rd(8'h32, 8'h03, 8'h05);
        end
        wr(8'h36, 8'h07);
        wr(8'h30, 8'he0);
        wr(8'h31, 8'hc0);
        #1 check({4'h0, wa_en, wa, wb_en, wb}, 8'h0e);
        rdx(8'h36, 8'h00);
        rdx(8'h31, 8'h00);
        wr(8'h30, 8'h70);
        wr(8'h31, 8'hc0);
        #1 check({4'h0, wa_en, wa, wb_en, wb}, 8'h0b);
        wr(8'h30, 8'h71);
        wr(8'h31, 8'h00);
        #1 check({4'h0, wa_en, wa, wb_en, wb}, 8'h0b);
        wr(8'h30, 8'h00);
        wr(8'h37, 8'h40);
        wr(8'h37, 8'h60);
        #1 check({6'h0, xbuf, xtal}, 8'h02);
        wr(8'h33, va);
        rdx(8'h37, 8'h68);
        wr(8'h23, 8'h02);
        rdx(8'h23, 8'h02);
        osc_en <= 1'b1;
        tick(200);
        rdx(8'h37, 8'h60);
        rdx(8'h23, 8'h00);
        rdx(8'h33, va);
        wr(8'h23, 8'h82);
        tick(100);
        rdx(8'h23, 8'h82);
        osc_en <= 1'b0;
        tick(2);
        close_out;
    end

    initial begin
        #400000;
        fails++;
        close_out;
    end
endmodule
